// *** inc/ifd_decode_map.svh ***
// Purpose: offsets, field positions and fixed values of the instruction field decoder
// Assumes: instruction bits numbered 0 (msb) to 31 (lsb)
// Notes: IFD_BIT turns a big-endian bit number into a vector index
`ifndef IFD_DECODE_MAP_SVH
`define IFD_DECODE_MAP_SVH

`define IFD_BIT(n) (31 - (n))

// field positions, big-endian numbering
`define IFD_OPC_HI 0
`define IFD_OPC_LO 5
`define IFD_TGT_HI 6
`define IFD_TGT_LO 10
`define IFD_GPA_HI 11
`define IFD_GPA_LO 15
`define IFD_GPB_HI 16
`define IFD_GPB_LO 20
`define IFD_IMM_HI 16
`define IFD_IMM_LO 19
`define IFD_LEVEL_HI 20
`define IFD_LEVEL_LO 26
`define IFD_FPC_HI 21
`define IFD_FPC_LO 25
`define IFD_MSTART_HI 21
`define IFD_MSTART_LO 25
`define IFD_MSTOP_HI 26
`define IFD_MSTOP_LO 30
`define IFD_NBYTES_HI 16
`define IFD_NBYTES_LO 20
`define IFD_DISP_HI 6
`define IFD_DISP_LO 29
`define IFD_OE_POS 21
`define IFD_ABS_POS 30
`define IFD_LINK_POS 31

// fixed values
`define IFD_SVC_ABS_ADDR 32'h0000_1FE0
`define IFD_LINK_STEP 32'h0000_0004

// register offsets
`define IFD_REG_CTRL 8'h00
`define IFD_REG_LINK 8'h04
`define IFD_REG_EXCEPT 8'h08
`define IFD_REG_LAST 8'h0C
`define IFD_REG_MASK 8'h10
`define IFD_REG_COUNT 8'h14

// register fields and reset values
`define IFD_CTRL_EN_POS 0
`define IFD_EXC_OVF_POS 0
`define IFD_EXC_SUM_POS 1
`define IFD_CTRL_RESET 32'h0000_0001

`endif

// *** inc/ifd_types_pkg.sv ***
// Purpose: shared types of the instruction field decoder
// Assumes: nothing beyond the map header
// Notes: widths and instruction classes only; positions, offsets and fixed values live in the map header
package ifd_types_pkg;
    typedef logic [31:0] word_t;
    typedef logic [4:0] reg_idx_t;
    typedef logic [5:0] opcode_t;
    typedef logic [7:0] reg_addr_t;
    typedef enum logic [1:0] {
        CLASS_OTHER,
        CLASS_BRANCH,
        CLASS_SVC
    } instr_class_t;
endpackage

// *** hw/rotate_mask_gen.sv ***
// Purpose: build the 32-bit rotate mask from start and stop indices
// Assumes: indices use big-endian numbering, bit 0 is the msb
// Notes: purely combinational
`timescale 1ns/1ps
`include "ifd_decode_map.svh"
module rotate_mask_gen
    import ifd_types_pkg::*;
(
    // indices
    input wire reg_idx_t start_idx,
    input wire reg_idx_t stop_idx,
    // result
    output word_t mask
);
    logic wraps;
    assign wraps = (start_idx > stop_idx);

    for (genvar i = 0; i < 32; i++) begin : g_bit
        localparam reg_idx_t POS = reg_idx_t'(i);
        logic in_span;
        assign in_span = (POS >= start_idx) && (POS <= stop_idx);
        // wrapped case: zeros strictly between stop and start
        assign mask[`IFD_BIT(i)] = wraps ? ((POS >= start_idx) || (POS <= stop_idx)) : in_span;
    end
endmodule

// *** hw/svc_target_gen.sv ***
// Purpose: form the supervisor-call routine address
// Assumes: level is the 7-bit service level
// Notes: purely combinational
`timescale 1ns/1ps
`include "ifd_decode_map.svh"
module svc_target_gen
    import ifd_types_pkg::*;
(
    // call fields
    input wire logic [6:0] level,
    input wire logic absolute,
    // result
    output word_t target
);
    assign target = absolute ? `IFD_SVC_ABS_ADDR : {19'h0_0000, 1'b1, level, 5'h00};
endmodule

// *** hw/instruction_field_decoder.sv ***
// Purpose: decode the fixed fields of a 32-bit instruction word
// Assumes: fetch presents one word per cycle with its address; plain register port
// Notes: decoded fields appear one cycle after the word is taken
`timescale 1ns/1ps
`include "ifd_decode_map.svh"
module instruction_field_decoder
    import ifd_types_pkg::*;
#(
    parameter opcode_t BRANCH_OPCODE = 6'h01,
    parameter opcode_t COND_BRANCH_OPCODE = 6'h02,
    parameter opcode_t SVC_OPCODE = 6'h03
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // fetch side
    input wire logic instr_valid,
    input wire word_t instr_word,
    input wire word_t instr_addr,
    // overflow report from extended arithmetic
    input wire logic overflow_valid,
    input wire logic overflow_result,
    // register port
    input wire reg_addr_t reg_addr,
    input wire word_t reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output word_t reg_rdata,
    // decoded fields
    output logic dec_valid,
    output instr_class_t instr_class,
    output opcode_t primary_opcode,
    output reg_idx_t fp_source_c,
    output reg_idx_t fp_store_source,
    output reg_idx_t fp_target,
    output logic [3:0] status_field_imm,
    output logic [6:0] service_level,
    output logic call_absolute_bit,
    output word_t supervisor_call_target,
    output word_t branch_displacement,
    output logic link_bit,
    output reg_idx_t mask_start_index,
    output reg_idx_t mask_stop_index,
    output word_t rotate_mask,
    output reg_idx_t string_byte_count,
    output logic overflow_enable,
    output reg_idx_t gp_operand_a,
    output reg_idx_t gp_operand_b,
    // architected state
    output word_t link_register,
    output logic overflow_flag,
    output logic summary_overflow
);
    // raw field slices
    logic take;
    opcode_t w_opcode;
    reg_idx_t w_tgt, w_gpa, w_gpb, w_fpc, w_mstart, w_mstop, w_nbytes;
    logic [3:0] w_imm;
    logic [6:0] w_level;
    logic [23:0] w_disp;
    logic w_oe, w_abs, w_link;
    word_t w_mask, w_svc;
    instr_class_t w_class;

    logic decode_en;
    assign take = instr_valid && decode_en;

    assign w_opcode = instr_word[`IFD_BIT(`IFD_OPC_HI):`IFD_BIT(`IFD_OPC_LO)];
    assign w_tgt = instr_word[`IFD_BIT(`IFD_TGT_HI):`IFD_BIT(`IFD_TGT_LO)];
    assign w_fpc = instr_word[`IFD_BIT(`IFD_FPC_HI):`IFD_BIT(`IFD_FPC_LO)];
    assign w_gpa = instr_word[`IFD_BIT(`IFD_GPA_HI):`IFD_BIT(`IFD_GPA_LO)];
    assign w_gpb = instr_word[`IFD_BIT(`IFD_GPB_HI):`IFD_BIT(`IFD_GPB_LO)];
    assign w_imm = instr_word[`IFD_BIT(`IFD_IMM_HI):`IFD_BIT(`IFD_IMM_LO)];
    assign w_level = instr_word[`IFD_BIT(`IFD_LEVEL_HI):`IFD_BIT(`IFD_LEVEL_LO)];
    assign w_mstart = instr_word[`IFD_BIT(`IFD_MSTART_HI):`IFD_BIT(`IFD_MSTART_LO)];
    assign w_mstop = instr_word[`IFD_BIT(`IFD_MSTOP_HI):`IFD_BIT(`IFD_MSTOP_LO)];
    assign w_nbytes = instr_word[`IFD_BIT(`IFD_NBYTES_HI):`IFD_BIT(`IFD_NBYTES_LO)];
    assign w_disp = instr_word[`IFD_BIT(`IFD_DISP_HI):`IFD_BIT(`IFD_DISP_LO)];
    assign w_oe = instr_word[`IFD_BIT(`IFD_OE_POS)];
    assign w_abs = instr_word[`IFD_BIT(`IFD_ABS_POS)];
    assign w_link = instr_word[`IFD_BIT(`IFD_LINK_POS)];

    always_comb begin
        if (w_opcode == SVC_OPCODE) begin
            w_class = CLASS_SVC;
        end else if (w_opcode == BRANCH_OPCODE || w_opcode == COND_BRANCH_OPCODE) begin
            w_class = CLASS_BRANCH;
        end else begin
            w_class = CLASS_OTHER;
        end
    end

    rotate_mask_gen u_mask (
        .start_idx(w_mstart),
        .stop_idx(w_mstop),
        .mask(w_mask)
    );

    svc_target_gen u_svc (
        .level(w_level),
        .absolute(w_abs),
        .target(w_svc)
    );

    // decoded field stage
    logic next_dec_valid;
    always_comb begin
        next_dec_valid = take;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dec_valid <= 1'b0;
            instr_class <= CLASS_OTHER;
            primary_opcode <= '0;
            fp_source_c <= '0;
            fp_store_source <= '0;
            fp_target <= '0;
            status_field_imm <= '0;
            service_level <= '0;
            call_absolute_bit <= 1'b0;
            supervisor_call_target <= '0;
            branch_displacement <= '0;
            link_bit <= 1'b0;
            mask_start_index <= '0;
            mask_stop_index <= '0;
            rotate_mask <= '0;
            string_byte_count <= '0;
            overflow_enable <= 1'b0;
            gp_operand_a <= '0;
            gp_operand_b <= '0;
        end else begin
            dec_valid <= next_dec_valid;
            // fields hold their last value while nothing is taken
            if (take) begin
                instr_class <= w_class;
                primary_opcode <= w_opcode;
                fp_source_c <= w_fpc;
                fp_store_source <= w_tgt;
                fp_target <= w_tgt;
                status_field_imm <= w_imm;
                service_level <= w_level;
                call_absolute_bit <= w_abs;
                supervisor_call_target <= w_svc;
                branch_displacement <= {{6{w_disp[23]}}, w_disp, 2'b00};
                link_bit <= w_link;
                mask_start_index <= w_mstart;
                mask_stop_index <= w_mstop;
                rotate_mask <= w_mask;
                string_byte_count <= w_nbytes;
                overflow_enable <= w_oe;
                gp_operand_a <= w_gpa;
                gp_operand_b <= w_gpb;
            end
        end
    end

    // software and architected state
    word_t next_link, last_word, next_last, count, next_count;
    logic next_overflow_flag, next_summary_overflow, next_decode_en;
    logic wr_ctrl, wr_link, wr_except;
    assign wr_ctrl = reg_write && (reg_addr == `IFD_REG_CTRL);
    assign wr_link = reg_write && (reg_addr == `IFD_REG_LINK);
    assign wr_except = reg_write && (reg_addr == `IFD_REG_EXCEPT);

    always_comb begin
        next_decode_en = wr_ctrl ? reg_wdata[`IFD_CTRL_EN_POS] : decode_en;
        next_last = take ? instr_word : last_word;
        next_count = take ? count + 32'h0000_0001 : count;
        next_link = wr_link ? reg_wdata : link_register;
        // hardware load beats a software write
        if (take && w_link && (w_class != CLASS_OTHER)) begin
            next_link = instr_addr + `IFD_LINK_STEP;
        end
        // write-one clears first, so a same-cycle update wins
        next_overflow_flag = overflow_flag && !(wr_except && reg_wdata[`IFD_EXC_OVF_POS]);
        next_summary_overflow = summary_overflow && !(wr_except && reg_wdata[`IFD_EXC_SUM_POS]);
        if (overflow_valid && overflow_enable) begin
            next_overflow_flag = overflow_result;
            next_summary_overflow = next_summary_overflow || overflow_result;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            decode_en <= 1'(`IFD_CTRL_RESET);
            link_register <= '0;
            last_word <= '0;
            count <= '0;
            overflow_flag <= 1'b0;
            summary_overflow <= 1'b0;
        end else begin
            decode_en <= next_decode_en;
            link_register <= next_link;
            last_word <= next_last;
            count <= next_count;
            overflow_flag <= next_overflow_flag;
            summary_overflow <= next_summary_overflow;
        end
    end

    // read port, data stand one cycle after the strobe
    word_t next_rdata;
    always_comb begin
        next_rdata = '0;
        if (reg_read) begin
            case (reg_addr)
                `IFD_REG_CTRL: next_rdata = {31'h0000_0000, decode_en};
                `IFD_REG_LINK: next_rdata = link_register;
                `IFD_REG_EXCEPT: next_rdata = {30'h0000_0000, summary_overflow, overflow_flag};
                `IFD_REG_LAST: next_rdata = last_word;
                `IFD_REG_MASK: next_rdata = rotate_mask;
                `IFD_REG_COUNT: next_rdata = count;
                default: next_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    // checks
    property p_opcode;
        @(posedge clk) disable iff (!resetn)
        take |=> dec_valid && primary_opcode == $past(instr_word[31:26]);
    endproperty
    a_opcode: assert property (p_opcode) else $error("opcode field wrong");

    property p_fp_fields;
        @(posedge clk) disable iff (!resetn)
        take |=> fp_source_c == $past(instr_word[10:6]) && fp_target == $past(instr_word[25:21]);
    endproperty
    a_fp_fields: assert property (p_fp_fields) else $error("fp register fields wrong");

    property p_imm;
        @(posedge clk) disable iff (!resetn)
        take |=> status_field_imm == $past(instr_word[15:12]);
    endproperty
    a_imm: assert property (p_imm) else $error("status immediate wrong");

    property p_svc_rel;
        @(posedge clk) disable iff (!resetn)
        take && !instr_word[1] |=>
            supervisor_call_target == {19'h0_0000, 1'b1, $past(instr_word[11:5]), 5'h00};
    endproperty
    a_svc_rel: assert property (p_svc_rel) else $error("relative call target wrong");

    property p_svc_abs;
        @(posedge clk) disable iff (!resetn)
        take && instr_word[1] |=> call_absolute_bit && supervisor_call_target == 32'h0000_1FE0;
    endproperty
    a_svc_abs: assert property (p_svc_abs) else $error("absolute call target wrong");

    property p_disp;
        @(posedge clk) disable iff (!resetn)
        take |=> branch_displacement[1:0] == 2'b00
            && $signed(branch_displacement) == $signed({$past(instr_word[25:2]), 2'b00});
    endproperty
    a_disp: assert property (p_disp) else $error("branch displacement wrong");

    property p_link_keep;
        @(posedge clk) disable iff (!resetn)
        take && !instr_word[0] && !wr_link |=> $stable(link_register);
    endproperty
    a_link_keep: assert property (p_link_keep) else $error("link register changed");

    property p_link_load;
        @(posedge clk) disable iff (!resetn)
        take && instr_word[0] && w_class != CLASS_OTHER |=>
            link_register == $past(instr_addr) + 32'h0000_0004;
    endproperty
    a_link_load: assert property (p_link_load) else $error("link register not loaded");

    property p_mask_ends;
        @(posedge clk) disable iff (!resetn)
        take |=> rotate_mask[31 - mask_start_index] && rotate_mask[31 - mask_stop_index]
            && mask_start_index == $past(instr_word[10:6]);
    endproperty
    a_mask_ends: assert property (p_mask_ends) else $error("mask ends not set");

    property p_mask_wrap;
        @(posedge clk) disable iff (!resetn)
        dec_valid && mask_start_index > mask_stop_index + 5'd1 |->
            !rotate_mask[31 - (mask_stop_index + 5'd1)];
    endproperty
    a_mask_wrap: assert property (p_mask_wrap) else $error("wrapped mask gap wrong");

    property p_nb;
        @(posedge clk) disable iff (!resetn)
        take |=> string_byte_count == $past(instr_word[15:11]);
    endproperty
    a_nb: assert property (p_nb) else $error("string byte count wrong");

    property p_overflow_inhibit;
        @(posedge clk) disable iff (!resetn)
        overflow_valid && !overflow_enable && !wr_except |=>
            $stable(overflow_flag) && $stable(summary_overflow);
    endproperty
    a_overflow_inhibit: assert property (p_overflow_inhibit) else $error("overflow flags moved");

    property p_gpr;
        @(posedge clk) disable iff (!resetn)
        take |=> gp_operand_a == $past(instr_word[20:16]) && gp_operand_b == $past(instr_word[15:11]);
    endproperty
    a_gpr: assert property (p_gpr) else $error("general register fields wrong");
endmodule

// *** bench/fetch_exec_model.sv ***
// Purpose: stand-in for fetch and execution feeding the decoder
// Assumes: bench raises each request for one cycle
// Notes: idle data lines show the inverse of their last value and valid lines drop low, so stale data cannot pass
`timescale 1ns/1ps
module fetch_exec_model
    import ifd_types_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // requests from the bench
    input wire logic fetch_go,
    input wire word_t fetch_word,
    input wire word_t fetch_addr,
    input wire logic overflow_go,
    input wire logic overflow_in,
    // toward the decoder
    output logic instr_valid,
    output word_t instr_word,
    output word_t instr_addr,
    output logic overflow_valid,
    output logic overflow_result
);
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            instr_valid <= 1'b0;
            instr_word <= '0;
            instr_addr <= '0;
            overflow_valid <= 1'b0;
            overflow_result <= 1'b0;
        end else begin
            instr_valid <= fetch_go;
            instr_word <= fetch_go ? fetch_word : ~instr_word;
            instr_addr <= fetch_go ? fetch_addr : ~instr_addr;
            overflow_valid <= overflow_go;
            overflow_result <= overflow_go ? overflow_in : ~overflow_result;
        end
    end
endmodule

// *** bench/instruction_field_decoder_test.sv ***
// Purpose: self-checking bench of the instruction field decoder
// Assumes: one-cycle decode latency, register map as handed over
// Notes: corner words first, then seeded random words with overflow reports
`timescale 1ns/1ps
`include "ifd_decode_map.svh"
module instruction_field_decoder_test
    import ifd_types_pkg::*;
;
    localparam opcode_t BR_OP = 6'h01;
    localparam opcode_t CBR_OP = 6'h02;
    localparam opcode_t SVC_OP = 6'h03;
    logic clk, resetn, go, og, oi, instr_valid, overflow_valid, overflow_result;
    word_t fw, fa, instr_word, instr_addr, reg_wdata, reg_rdata, w, a;
    reg_addr_t reg_addr;
    logic reg_write, reg_read;
    logic dec_valid, call_absolute_bit, link_bit, overflow_enable;
    logic overflow_flag, summary_overflow;
    instr_class_t instr_class, ec;
    opcode_t primary_opcode;
    reg_idx_t fp_source_c, fp_store_source, fp_target, mask_start_index, mask_stop_index;
    reg_idx_t string_byte_count, gp_operand_a, gp_operand_b;
    logic [3:0] status_field_imm;
    logic [6:0] service_level;
    word_t supervisor_call_target, branch_displacement, rotate_mask, link_register;
    int n_mismatch, checks_done, seed, i, cycles, n_taken;
    word_t el, lw, lm;
    logic eo, es;
    // mask wrap, single bit, full span, absolute call, negative displacement
    word_t corner [8] = '{32'h0400_0001, 32'h0800_0001, 32'h0C00_0003, 32'h0C00_0FE0,
                          32'h0200_0000, 32'h0000_014A, 32'h0000_07C0, 32'h0000_003E};

    fetch_exec_model u_fetch_exec_model (.clk(clk), .resetn(resetn), .fetch_go(go),
        .fetch_word(fw), .fetch_addr(fa), .overflow_go(og), .overflow_in(oi),
        .instr_valid(instr_valid), .instr_word(instr_word), .instr_addr(instr_addr),
        .overflow_valid(overflow_valid), .overflow_result(overflow_result));
    instruction_field_decoder #(.BRANCH_OPCODE(BR_OP), .COND_BRANCH_OPCODE(CBR_OP),
        .SVC_OPCODE(SVC_OP)) u_instruction_field_decoder (.clk(clk), .resetn(resetn),
        .instr_valid(instr_valid), .instr_word(instr_word), .instr_addr(instr_addr),
        .overflow_valid(overflow_valid), .overflow_result(overflow_result), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .dec_valid(dec_valid), .instr_class(instr_class),
        .primary_opcode(primary_opcode), .fp_source_c(fp_source_c),
        .fp_store_source(fp_store_source), .fp_target(fp_target),
        .status_field_imm(status_field_imm), .service_level(service_level),
        .call_absolute_bit(call_absolute_bit), .supervisor_call_target(supervisor_call_target),
        .branch_displacement(branch_displacement), .link_bit(link_bit),
        .mask_start_index(mask_start_index), .mask_stop_index(mask_stop_index),
        .rotate_mask(rotate_mask), .string_byte_count(string_byte_count),
        .overflow_enable(overflow_enable), .gp_operand_a(gp_operand_a),
        .gp_operand_b(gp_operand_b), .link_register(link_register),
        .overflow_flag(overflow_flag), .summary_overflow(summary_overflow));

    always #2.5 clk = ~clk;

    function automatic word_t exp_mask(input reg_idx_t s, input reg_idx_t e);
        word_t m;
        for (int k = 0; k < 32; k++) begin
            if (s <= e) m[31-k] = (k >= s) && (k <= e);
            else m[31-k] = !((k > e) && (k < s));
        end
        return m;
    endfunction

    function automatic word_t exp_svc(input logic [6:0] lvl, input logic abs_bit);
        return abs_bit ? `IFD_SVC_ABS_ADDR : {19'h0, 1'b1, lvl, 5'h00};
    endfunction

    task automatic complete_run();
        $display("checks_done %0d n_mismatch %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic issue(input word_t iw, input word_t ia, input logic take);
        @(posedge clk);
        go <= 1'b1;
        fw <= iw;
        fa <= ia;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        #1;
        cmp(32'(dec_valid), 32'(take), "dec_valid");
        if (!take) begin
            cmp(32'(primary_opcode), 32'(lw[31:26]), "held opcode");
            return;
        end
        lw = iw;
        lm = exp_mask(iw[10:6], iw[5:1]);
        n_taken++;
        ec = CLASS_OTHER;
        if (iw[31:26] == SVC_OP) ec = CLASS_SVC;
        else if (iw[31:26] == BR_OP || iw[31:26] == CBR_OP) ec = CLASS_BRANCH;
        if (iw[0] && ec != CLASS_OTHER) el = ia + `IFD_LINK_STEP;
        cmp(32'(primary_opcode), 32'(iw[31:26]), "opcode");
        cmp(32'(instr_class), 32'(ec), "class");
        cmp(32'(fp_source_c), 32'(iw[10:6]), "fp c");
        cmp(32'(fp_store_source), 32'(iw[25:21]), "fp s");
        cmp(32'(fp_target), 32'(iw[25:21]), "fp t");
        cmp(32'(status_field_imm), 32'(iw[15:12]), "imm");
        cmp(32'(service_level), 32'(iw[11:5]), "level");
        cmp(32'(call_absolute_bit), 32'(iw[1]), "abs");
        cmp(supervisor_call_target, exp_svc(iw[11:5], iw[1]), "svc");
        cmp(branch_displacement, {{6{iw[25]}}, iw[25:2], 2'h0}, "disp");
        cmp(32'(link_bit), 32'(iw[0]), "link bit");
        cmp(link_register, el, "link reg");
        cmp(32'(mask_start_index), 32'(iw[10:6]), "mstart");
        cmp(32'(mask_stop_index), 32'(iw[5:1]), "mstop");
        cmp(rotate_mask, lm, "mask");
        cmp(32'(string_byte_count), 32'(iw[15:11]), "nbytes");
        cmp(32'(overflow_enable), 32'(iw[10]), "oe");
        cmp(32'(gp_operand_a), 32'(iw[20:16]), "gpa");
        cmp(32'(gp_operand_b), 32'(iw[15:11]), "gpb");
    endtask

    task automatic ovr(input logic v);
        @(posedge clk);
        og <= 1'b1;
        oi <= v;
        @(posedge clk);
        og <= 1'b0;
        @(posedge clk);
        #1;
        if (lw[10]) begin
            eo = v;
            es = es | v;
        end
        cmp(32'(overflow_flag), 32'(eo), "overflow flag");
        cmp(32'(summary_overflow), 32'(es), "so flag");
    endtask

    task automatic wr(input reg_addr_t ra, input word_t d);
        @(posedge clk);
        reg_addr <= ra;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input reg_addr_t ra, input word_t e, input string msg);
        @(posedge clk);
        reg_addr <= ra;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 cmp(reg_rdata, e, msg);
    endtask

    // cut a hang short; the run needs well under 2000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            complete_run();
        end
    end

    initial begin
        clk = 0; resetn = 0; go = 0; og = 0; oi = 0; fw = '0; fa = '0;
        reg_addr = '0; reg_wdata = '0; reg_write = 0; reg_read = 0;
        seed = 38; n_mismatch = 0; checks_done = 0; cycles = 0; n_taken = 0;
        el = '0; lw = '0; lm = '0; eo = 0; es = 0;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        rd(`IFD_REG_CTRL, `IFD_CTRL_RESET, "ctrl reset");
        rd(`IFD_REG_LINK, '0, "link reset");
        $display("test reset done");
        for (i = 0; i < 8; i++) issue(corner[i], 32'h0000_1000 + 32'(i * 4), 1'b1);
        $display("test corners done");
        for (i = 0; i < 60; i++) begin
            w = $random(seed);
            a = $random(seed);
            if (i < 16) w[31:26] = 6'(i % 4);
            issue(w, a, 1'b1);
            ovr(1'($random(seed)));
        end
        $display("test random done");
        rd(`IFD_REG_LAST, lw, "last word");
        rd(`IFD_REG_MASK, lm, "last mask");
        rd(`IFD_REG_COUNT, 32'(n_taken), "count");
        rd(`IFD_REG_EXCEPT, {30'h0, es, eo}, "exc reg");
        wr(`IFD_REG_EXCEPT, 32'h0000_0003);
        eo = 0;
        es = 0;
        rd(`IFD_REG_EXCEPT, '0, "exc reg clear");
        el = 32'h1234_5670;
        wr(`IFD_REG_LINK, el);
        rd(`IFD_REG_LINK, el, "link write");
        issue(32'h0400_0000, 32'h0000_2000, 1'b1);
        wr(`IFD_REG_CTRL, '0);
        issue(32'h0800_0001, 32'h0000_3000, 1'b0);
        rd(`IFD_REG_COUNT, 32'(n_taken), "count held");
        rd(`IFD_REG_LINK, el, "link held");
        wr(`IFD_REG_COUNT, 32'h0000_00FF);
        rd(`IFD_REG_COUNT, 32'(n_taken), "ro count");
        rd(8'h20, '0, "unmapped");
        wr(`IFD_REG_CTRL, 32'h0000_0001);
        issue(32'h0C00_0001, 32'h0000_4000, 1'b1);
        $display("test registers done");
        complete_run();
    end
endmodule
